// ### ucb_top.sv
// Local design decisions: the address map and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module ucb_top (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Bit-rate tick, sixteen per bit, from the timer.
  input wire logic baud_tick_i,
  // Serial line.
  input wire logic rxd_i,
  output logic txd_o,
  // Interrupt.
  output logic irq_o,
  // AXI4-Lite write address channel.
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_awaddr_i,
  // AXI4-Lite write data channel.
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  // AXI4-Lite write response channel.
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  // AXI4-Lite read address channel.
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [31:0] s_axi_araddr_i,
  // AXI4-Lite read data channel.
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o
);
  import ucb_pkg::*;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    // Bus slave.
    logic aw_full; // Write address held.
    logic [2:0] aw_sel; // Decoded write target.
    logic w_full; // Write data held.
    logic [7:0] w_data; // Low byte of write data.
    logic w_lane; // Byte lane zero enabled.
    logic awready; // Ready for a write address.
    logic wready; // Ready for write data.
    logic bvalid; // Write response pending.
    logic [1:0] bresp; // Write response code.
    logic arready; // Ready for a read address.
    logic rvalid; // Read data pending.
    logic [31:0] rdata; // Read data.
    logic [1:0] rresp; // Read response code.
    // Serial port control.
    logic mode9; // Nine-bit frame mode.
    logic mce; // Multiprocessor filter enable.
    logic ren; // Receive enable.
    logic tb8; // Ninth transmit bit.
    logic rb8; // Ninth receive bit.
    logic ti; // Transmit flag.
    logic ri; // Receive flag.
    logic [7:0] rx_buf; // Receive latch.
    // Interrupt block.
    logic [1:0] irq_stat; // Sticky events.
    logic [1:0] irq_mask; // Event enables.
    logic irq; // Registered interrupt line.
    // Input synchroniser.
    logic rxd_meta; // First stage.
    logic rxd_sync; // Second stage.
    // Transmitter.
    ucb_state_t tx_st; // Frame position.
    logic [3:0] tx_tick; // Ticks into the current bit.
    logic [2:0] tx_bitn; // Data bit index.
    logic [7:0] tx_shift; // Transmit shift register.
    logic tx_ninth; // Ninth bit of this frame.
    logic txd; // Registered line level.
  } ucb_top_st_t;

  ucb_top_st_t q;
  ucb_top_st_t d;
  logic [7:0] ctl_view; // Control register as software sees it.
  logic rx_accept; // Finished frame passes the load checks.

  ucb_rx_if rx_link ();

  // --------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------
  assign rx_link.ren = q.ren;
  assign rx_link.mode9 = q.mode9;
  assign rx_link.rxd = q.rxd_sync;
  assign rx_link.tick = baud_tick_i;

  ucb_rx u_rx (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .port_if(rx_link)
  );

  // Control register image, unused bit six reads as one.
  always_comb begin
    ctl_view = 8'h00;
    ctl_view[UCB_CTL_MODE] = q.mode9;
    ctl_view[UCB_CTL_ONE] = 1'b1;
    ctl_view[UCB_CTL_MCE] = q.mce;
    ctl_view[UCB_CTL_REN] = q.ren;
    ctl_view[UCB_CTL_TB8] = q.tb8;
    ctl_view[UCB_CTL_RB8] = q.rb8;
    ctl_view[UCB_CTL_TI] = q.ti;
    ctl_view[UCB_CTL_RI] = q.ri;
  end

  // A frame loads only into a free latch; the filter checks the ninth
  // bit in nine-bit mode and the stop bit in eight-bit mode.
  always_comb begin
    if (q.mce) begin
      rx_accept = !q.ri && (q.mode9 ? rx_link.ninth : rx_link.stop); // [R1] [R13]
    end else begin
      rx_accept = !q.ri; // [R13]
    end
  end

  // --------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------
  // Bus accesses are applied first so that hardware sets override
  // a clear written in the same cycle.
  always_comb begin
    d = q;
    d.rxd_meta = rxd_i;
    d.rxd_sync = q.rxd_meta;

    // Write address and data are taken independently.
    if (s_axi_awvalid_i && q.awready) begin
      d.aw_full = 1'b1;
      d.aw_sel = ucb_decode(s_axi_awaddr_i);
    end
    if (s_axi_wvalid_i && q.wready) begin
      d.w_full = 1'b1;
      d.w_data = s_axi_wdata_i[7:0];
      d.w_lane = s_axi_wstrb_i[0];
    end
    if (q.bvalid && s_axi_bready_i) begin
      d.bvalid = 1'b0;
    end

    // Both halves held: perform the write and answer.
    if (q.aw_full && q.w_full && !q.bvalid) begin
      d.aw_full = 1'b0;
      d.w_full = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = (q.aw_sel == UCB_SEL_NONE) ? UCB_RESP_SLVERR : UCB_RESP_OKAY;
      if (q.w_lane) begin
        case (q.aw_sel)
          UCB_SEL_CTL: begin
            d.mode9 = q.w_data[UCB_CTL_MODE]; // [R11]
            d.mce = q.w_data[UCB_CTL_MCE];
            d.ren = q.w_data[UCB_CTL_REN]; // [R2]
            d.tb8 = q.w_data[UCB_CTL_TB8];
            d.rb8 = q.w_data[UCB_CTL_RB8];
            d.ti = q.w_data[UCB_CTL_TI]; // [R7]
            d.ri = q.w_data[UCB_CTL_RI]; // [R9]
          end
          UCB_SEL_BUF: begin
            // A write while a frame is on the line is dropped.
            if (q.tx_st == UCB_ST_IDLE) begin
              d.tx_shift = q.w_data; // [R12]
              d.tx_ninth = q.tb8; // [R3]
              d.tx_tick = 4'h0;
              d.tx_st = UCB_ST_START;
            end
          end
          UCB_SEL_STAT: d.irq_stat = q.irq_stat & ~q.w_data[1:0];
          UCB_SEL_MASK: d.irq_mask = q.w_data[1:0];
          default: d.bresp = UCB_RESP_SLVERR;
        endcase
      end
    end

    // Reads answer one cycle after the address is taken.
    if (q.rvalid && s_axi_rready_i) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid_i && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = UCB_RESP_OKAY;
      case (ucb_decode(s_axi_araddr_i))
        UCB_SEL_CTL: d.rdata = {24'h000000, ctl_view};
        UCB_SEL_BUF: d.rdata = {24'h000000, q.rx_buf}; // [R12]
        UCB_SEL_STAT: d.rdata = {30'h00000000, q.irq_stat};
        UCB_SEL_MASK: d.rdata = {30'h00000000, q.irq_mask};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = UCB_RESP_SLVERR;
        end
      endcase
    end

    // Transmitter walks one bit per sixteen ticks.
    if (baud_tick_i && (q.tx_st != UCB_ST_IDLE)) begin
      d.tx_tick = q.tx_tick + 4'h1; // [R15]
      if (q.tx_tick == UCB_TICK_LAST) begin
        case (q.tx_st)
          UCB_ST_START: begin
            d.tx_bitn = 3'h0;
            d.tx_st = UCB_ST_DATA;
          end
          UCB_ST_DATA: begin
            d.tx_shift = {1'b0, q.tx_shift[7:1]}; // [R14]
            d.tx_bitn = q.tx_bitn + 3'h1;
            if (q.tx_bitn == UCB_BIT_LAST) begin
              d.tx_st = q.mode9 ? UCB_ST_NINTH : UCB_ST_STOP; // [R11]
            end
          end
          UCB_ST_NINTH: begin
            d.tx_st = UCB_ST_STOP;
            d.ti = 1'b1; // [R6]
            d.irq_stat[UCB_CTL_TI] = 1'b1; // [R9]
          end
          UCB_ST_STOP: begin
            d.tx_st = UCB_ST_IDLE;
            if (!q.mode9) begin
              d.ti = 1'b1; // [R5]
              d.irq_stat[UCB_CTL_TI] = 1'b1; // [R9]
            end
          end
          default: d.tx_st = UCB_ST_IDLE;
        endcase
      end
    end

    // Line level follows the next frame position.
    case (d.tx_st)
      UCB_ST_START: d.txd = 1'b0;
      UCB_ST_DATA: d.txd = d.tx_shift[0];
      UCB_ST_NINTH: d.txd = d.tx_ninth; // [R3]
      default: d.txd = 1'b1;
    endcase

    // A finished frame loads the latch and raises the receive flag.
    if (rx_link.done && rx_accept) begin
      d.rx_buf = rx_link.data;
      d.rb8 = q.mode9 ? rx_link.ninth : rx_link.stop; // [R4]
      d.ri = 1'b1; // [R8]
      d.irq_stat[UCB_CTL_RI] = 1'b1; // [R9]
    end

    // Handshake readiness and the interrupt line, all registered.
    d.awready = !d.aw_full && !d.bvalid;
    d.wready = !d.w_full && !d.bvalid;
    d.arready = !d.rvalid;
    d.irq = |(d.irq_stat & d.irq_mask); // [R9]
  end

  // --------------------------------------------------------------
  // State register
  // --------------------------------------------------------------
  // Reset idles the line high and clears the data buffer.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
      q.rx_buf <= UCB_BUF_RESET; // [R10]
      q.tx_shift <= UCB_BUF_RESET; // [R10]
      q.irq_mask <= UCB_MASK_RESET;
      q.tx_st <= UCB_ST_IDLE;
      q.txd <= 1'b1;
      q.rxd_meta <= 1'b1;
      q.rxd_sync <= 1'b1; // [R16]
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  assign txd_o = q.txd;
  assign irq_o = q.irq;
  assign s_axi_awready_o = q.awready;
  assign s_axi_wready_o = q.wready;
  assign s_axi_bvalid_o = q.bvalid;
  assign s_axi_bresp_o = q.bresp;
  assign s_axi_arready_o = q.arready;
  assign s_axi_rvalid_o = q.rvalid;
  assign s_axi_rdata_o = q.rdata;
  assign s_axi_rresp_o = q.rresp;
endmodule
`default_nettype wire

// ### ucb_pkg.sv
// Notes on behaviour
// R1 - Filtering on: only ninth-bit-one frames flag.
// R2 - Receive enable zero blocks reception; one allows.
// R3 - Nine-bit frames send stored ninth transmit bit.
// R4 - Ninth receive bit: stop bit, or ninth bit.
// R5 - Eight-bit mode: transmit flag at frame end.
// R6 - Nine-bit mode: transmit flag at stop start.
// R7 - Software clears transmit flag; hardware never does.
// R8 - Receive flag set at stop bit sample.
// R9 - Flags raise enabled interrupt; software clears receive.
// R10 - Data buffer is eight bits, reset zero.
// R11 - Mode bit: zero eight-bit, one nine-bit frames.
// R12 - Buffer write starts transmit; read returns receive.
// R13 - Load only when receive flag clear, filter passes.
// R14 - Frame: start, eight data LSB first, ninth, stop.
// R15 - Bit timing from external tick, centre sampling.
// R16 - Remote sends matching frames, idles line high.
`default_nettype none
package ucb_pkg;

  // ----------------------------------------------------------------
  // Register map and field layout
  // ----------------------------------------------------------------
  localparam logic [31:0] UCB_OFF_CTL = 32'h0000_0000; // Serial port control.
  localparam logic [31:0] UCB_OFF_BUF = 32'h0000_0004; // Serial data buffer.
  localparam logic [31:0] UCB_OFF_STAT = 32'h0000_0008; // Interrupt status, write one to clear.
  localparam logic [31:0] UCB_OFF_MASK = 32'h0000_000c; // Interrupt mask.
  localparam logic [2:0] UCB_SEL_CTL = 3'h0;
  localparam logic [2:0] UCB_SEL_BUF = 3'h1;
  localparam logic [2:0] UCB_SEL_STAT = 3'h2;
  localparam logic [2:0] UCB_SEL_MASK = 3'h3;
  localparam logic [2:0] UCB_SEL_NONE = 3'h7;
  localparam int UCB_CTL_MODE = 7; // Frame mode select.
  localparam int UCB_CTL_ONE = 6; // Unused, reads as one.
  localparam int UCB_CTL_MCE = 5; // Multiprocessor filter enable.
  localparam int UCB_CTL_REN = 4; // Receive enable.
  localparam int UCB_CTL_TB8 = 3; // Ninth transmit bit.
  localparam int UCB_CTL_RB8 = 2; // Ninth receive bit.
  localparam int UCB_CTL_TI = 1; // Transmit flag.
  localparam int UCB_CTL_RI = 0; // Receive flag.
  localparam logic [7:0] UCB_BUF_RESET = 8'h00; // Data buffer reset value.
  localparam logic [1:0] UCB_MASK_RESET = 2'h0; // Interrupt mask reset value.

  // ----------------------------------------------------------------
  // Bus answers and bit timing
  // ----------------------------------------------------------------
  localparam logic [1:0] UCB_RESP_OKAY = 2'h0;
  localparam logic [1:0] UCB_RESP_SLVERR = 2'h2;
  localparam logic [3:0] UCB_TICK_LAST = 4'hf; // Sixteen ticks per bit.
  localparam logic [3:0] UCB_TICK_HALF = 4'h7; // Tick index of a start bit centre.
  localparam logic [2:0] UCB_BIT_LAST = 3'h7; // Index of the last data bit.

  // Serial frame sequencing shared by transmitter and receiver.
  typedef enum logic [2:0] {
    UCB_ST_IDLE = 3'b000,
    UCB_ST_START = 3'b001,
    UCB_ST_DATA = 3'b010,
    UCB_ST_NINTH = 3'b011,
    UCB_ST_STOP = 3'b100
  } ucb_state_t;

  // Maps a bus address onto a register select code.
  function automatic logic [2:0] ucb_decode(input logic [31:0] addr);
    logic [2:0] sel;
    sel = UCB_SEL_NONE;
    case (addr)
      UCB_OFF_CTL: sel = UCB_SEL_CTL;
      UCB_OFF_BUF: sel = UCB_SEL_BUF;
      UCB_OFF_STAT: sel = UCB_SEL_STAT;
      UCB_OFF_MASK: sel = UCB_SEL_MASK;
      default: sel = UCB_SEL_NONE;
    endcase
    return sel;
  endfunction

endpackage
`default_nettype wire

// ### ucb_rx_if.sv
`timescale 1ns/10ps
`default_nettype none
// Carries settings to the receiver and finished frames back.
interface ucb_rx_if;
  logic ren; // Reception allowed.
  logic mode9; // Nine-bit frames selected.
  logic rxd; // Synchronised serial input.
  logic tick; // Sixteen-times bit-rate tick.
  logic done; // One-cycle pulse at stop bit sampling.
  logic [7:0] data; // Received data byte.
  logic ninth; // Received ninth bit.
  logic stop; // Sampled stop bit level.
  modport rx (input ren, mode9, rxd, tick, output done, data, ninth, stop);
  modport ctl (output ren, mode9, rxd, tick, input done, data, ninth, stop);
endinterface
`default_nettype wire

// ### ucb_rx.sv
`timescale 1ns/10ps
`default_nettype none
module ucb_rx (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Link to the control logic.
  ucb_rx_if.rx port_if
);
  import ucb_pkg::*;

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    ucb_state_t st; // Frame position.
    logic [3:0] tick; // Ticks into the current bit.
    logic [2:0] bitn; // Data bit index.
    logic [7:0] shift; // Assembled data byte.
    logic ninth; // Ninth bit as sampled.
    logic done; // Frame finished pulse.
    logic [7:0] data; // Byte handed over.
    logic stop; // Stop level handed over.
  } ucb_rx_st_t;

  ucb_rx_st_t q;
  ucb_rx_st_t d;

  // Walks one frame, sampling each bit at its centre.
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (!port_if.ren) begin
      d.st = UCB_ST_IDLE; // [R2]
    end else if (port_if.tick) begin
      d.tick = q.tick + 4'h1; // [R15]
      case (q.st)
        UCB_ST_IDLE: begin
          d.tick = 4'h0;
          if (!port_if.rxd) begin
            d.st = UCB_ST_START;
          end
        end
        UCB_ST_START: begin
          if (q.tick == UCB_TICK_HALF) begin
            d.tick = 4'h0;
            d.bitn = 3'h0;
            d.st = port_if.rxd ? UCB_ST_IDLE : UCB_ST_DATA;
          end
        end
        UCB_ST_DATA: begin
          if (q.tick == UCB_TICK_LAST) begin
            d.shift = {port_if.rxd, q.shift[7:1]}; // [R14]
            d.bitn = q.bitn + 3'h1;
            if (q.bitn == UCB_BIT_LAST) begin
              d.st = port_if.mode9 ? UCB_ST_NINTH : UCB_ST_STOP;
            end
          end
        end
        UCB_ST_NINTH: begin
          if (q.tick == UCB_TICK_LAST) begin
            d.ninth = port_if.rxd;
            d.st = UCB_ST_STOP;
          end
        end
        UCB_ST_STOP: begin
          if (q.tick == UCB_TICK_LAST) begin
            d.done = 1'b1; // [R8]
            d.data = q.shift;
            d.stop = port_if.rxd;
            d.st = UCB_ST_IDLE;
          end
        end
        default: d.st = UCB_ST_IDLE;
      endcase
    end
  end

  // Registers the receiver state.
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign port_if.done = q.done;
  assign port_if.data = q.data;
  assign port_if.ninth = q.ninth;
  assign port_if.stop = q.stop;
endmodule
`default_nettype wire

// ### ucb_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Port checker for the serial port block
// ----------------------------------------------------------------
module ucb_chk (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Serial side.
  input wire logic baud_tick_i,
  input wire logic txd_o,
  input wire logic irq_o,
  // Register bus.
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o
);
  import ucb_pkg::*;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);

  // A write answer stands unchanged until it is taken.
  property p_bhold;
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");

  // A read answer stands unchanged until it is taken.
  property p_rhold;
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");

  // No second read is taken while an answer waits.
  property p_arblk;
    s_axi_rvalid_o |-> !s_axi_arready_o;
  endproperty
  a_arblk: assert property (p_arblk) else $error("read taken while answer waits");

  // A taken read is answered on the next edge.
  property p_rlat;
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");

  // Both write halves taken together are answered two edges later.
  property p_blat;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");

  // A read above the register block returns zero data.
  property p_rerr;
    s_axi_arvalid_i && s_axi_arready_o && (s_axi_araddr_i[31:4] != 28'h0)
      |=> s_axi_rdata_o == 32'h0;
  endproperty
  a_rerr: assert property (p_rerr) else $error("unmapped read returned data");

  // A start bit lasts at least eight cycles.
  property p_start;
    $fell(txd_o) |-> !txd_o [*8];
  endproperty
  a_start: assert property (p_start) else $error("start bit too short");

  // The line moves only on a bit tick or when a transmission starts.
  property p_txstep;
    $changed(txd_o) |-> $past(baud_tick_i) || $rose(s_axi_bvalid_o);
  endproperty
  a_txstep: assert property (p_txstep) else $error("line moved off a tick");

  // Main scenarios.
  c_irq: cover property ($rose(irq_o));
  c_tx: cover property ($fell(txd_o));
  c_err: cover property (s_axi_bvalid_o && s_axi_bresp_o == UCB_RESP_SLVERR);
endmodule

bind ucb_top ucb_chk i_ucb_chk (
  .clk_sys_i, .rst_i, .baud_tick_i, .txd_o, .irq_o,
  .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i,
  .s_axi_arready_o, .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o
);
`default_nettype wire

// ### ucb_remote.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Remote serial party on the far end of the line
// ----------------------------------------------------------------
module ucb_remote (
  // Clock.
  input wire logic clk_i,
  // Serial line.
  input wire logic txd_i,
  output logic rxd_o
);
  localparam int BIT_CYC = 32; // Sixteen ticks at one tick every two cycles.
  logic [10:0] got = 11'h7ff; // Last frame seen, start bit in bit 0.

  // The line idles high between frames.
  initial rxd_o = 1'b1;

  // Sends start, data LSB first, then ninth or stop bit, then stop.
  task automatic send(input logic [7:0] d, input logic b9, input logic nine);
    logic [10:0] f;
    f = {1'b1, b9, d, 1'b0};
    for (int i = 0; i < (nine ? 11 : 10); i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask

  // Samples every bit of the incoming frame near its centre.
  initial forever begin
    @(posedge clk_i);
    if (txd_i === 1'b0) begin
      repeat (BIT_CYC / 2 - 1) @(posedge clk_i);
      for (int i = 0; i < 11; i++) begin
        got[i] = txd_i;
        repeat (BIT_CYC) @(posedge clk_i);
      end
    end
  end
endmodule
`default_nettype wire

// ### ucb_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module ucb_tb_top;
  import ucb_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct packed {logic [7:0] ctl; logic [7:0] d; logic b9; logic ld;} ucb_row_t;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic baud_tick_i = 1'b0;
  logic rxd_i;
  logic txd_o;
  logic irq_o;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_awready_o;
  logic [31:0] s_axi_awaddr_i = 32'h0;
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_wready_o;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic s_axi_bvalid_o;
  logic s_axi_bready_i = 1'b0;
  logic [1:0] s_axi_bresp_o;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_arready_o;
  logic [31:0] s_axi_araddr_i = 32'h0;
  logic s_axi_rvalid_o;
  logic s_axi_rready_i = 1'b0;
  logic [31:0] s_axi_rdata_o;
  logic [1:0] s_axi_rresp_o;
  int errors = 0;
  int n_tests = 0;
  int n;
  logic [7:0] last_rx = 8'h00; // Receive latch contents expected.
  // Receive cases: control value, byte, ninth or stop bit, loaded.
  ucb_row_t rx_tab [7] = '{'{8'h00, 8'h5a, 1'b1, 1'b0}, '{8'h10, 8'h3c, 1'b1, 1'b1},
    '{8'h90, 8'hc3, 1'b0, 1'b1}, '{8'hb0, 8'h11, 1'b0, 1'b0}, '{8'hb0, 8'h22, 1'b1, 1'b1},
    '{8'h30, 8'h44, 1'b0, 1'b0}, '{8'h11, 8'h77, 1'b1, 1'b0}};
  // Transmit cases: control value and byte.
  logic [15:0] tx_tab [3] = '{16'h00a5, 16'h885a, 16'h8096};

  always #5 clk_sys_i = ~clk_sys_i;
  // Bit tick every second cycle, sixteen to a bit.
  always @(posedge clk_sys_i) baud_tick_i <= ~baud_tick_i;

  ucb_top i_ucb_top (
    .clk_sys_i, .rst_i, .baud_tick_i, .rxd_i, .txd_o, .irq_o,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_awaddr_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_wdata_i, .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_bresp_o, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_araddr_i, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_rdata_o, .s_axi_rresp_o
  );
  ucb_remote i_ucb_remote (.clk_i(clk_sys_i), .txd_i(txd_o), .rxd_o(rxd_i));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic complete_run;
    $display("errors=%0d n_tests=%0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write; the answer is accepted a little late on purpose.
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    s_axi_awvalid_i <= 1'b1;
    s_axi_awaddr_i <= a;
    s_axi_wvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    do begin
      @(posedge clk_sys_i);
      k++;
      if (s_axi_awready_o && s_axi_awvalid_i) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o && s_axi_wvalid_i) s_axi_wvalid_i <= 1'b0;
      if (k == 3) s_axi_bready_i <= 1'b1;
    end while (!(s_axi_bvalid_o && s_axi_bready_i) && k < 200);
    s_axi_bready_i <= 1'b0;
    if (k >= 200) begin
      errors++;
      complete_run();
    end
    chk("bresp", 32'(er), 32'(s_axi_bresp_o));
  endtask

  // Bus read with expected data and answer code.
  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er);
    int k;
    k = 0;
    @(posedge clk_sys_i);
    s_axi_arvalid_i <= 1'b1;
    s_axi_araddr_i <= a;
    do begin
      @(posedge clk_sys_i);
      k++;
      if (s_axi_arready_o && s_axi_arvalid_i) s_axi_arvalid_i <= 1'b0;
      if (k == 2) s_axi_rready_i <= 1'b1;
    end while (!(s_axi_rvalid_o && s_axi_rready_i) && k < 200);
    s_axi_rready_i <= 1'b0;
    if (k >= 200) begin
      errors++;
      complete_run();
    end
    chk("rdata", ed, s_axi_rdata_o);
    chk("rresp", 32'(er), 32'(s_axi_rresp_o));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rd(UCB_OFF_CTL, 32'h40, UCB_RESP_OKAY);
    rd(UCB_OFF_BUF, 32'h0, UCB_RESP_OKAY);
    rd(UCB_OFF_MASK, 32'h0, UCB_RESP_OKAY);
    rd(32'h10, 32'h0, UCB_RESP_SLVERR);
    wr(32'h14, 32'h1, UCB_RESP_SLVERR);
    wr(UCB_OFF_MASK, 32'h1, UCB_RESP_OKAY);
    foreach (rx_tab[i]) begin
      wr(UCB_OFF_STAT, 32'h3, UCB_RESP_OKAY);
      chk("irq_clear", 32'h0, 32'(irq_o));
      wr(UCB_OFF_CTL, 32'(rx_tab[i].ctl), UCB_RESP_OKAY);
      i_ucb_remote.send(rx_tab[i].d, rx_tab[i].b9, rx_tab[i].ctl[7]);
      repeat (40) @(posedge clk_sys_i);
      if (rx_tab[i].ld) last_rx = rx_tab[i].d;
      rd(UCB_OFF_CTL, 32'h40 | 32'(rx_tab[i].ctl) | (rx_tab[i].ld ? (32'(rx_tab[i].b9) << 2) | 32'h1 : 32'h0),
        UCB_RESP_OKAY);
      rd(UCB_OFF_BUF, 32'(last_rx), UCB_RESP_OKAY);
      chk("irq_rx", 32'(rx_tab[i].ld), 32'(irq_o));
      if (rx_tab[i].ld) begin
        rd(UCB_OFF_STAT, 32'h1, UCB_RESP_OKAY);
        wr(UCB_OFF_MASK, 32'h0, UCB_RESP_OKAY);
        chk("irq_masked", 32'h0, 32'(irq_o));
        wr(UCB_OFF_MASK, 32'h1, UCB_RESP_OKAY);
      end
    end
    wr(UCB_OFF_MASK, 32'h2, UCB_RESP_OKAY);
    foreach (tx_tab[i]) begin
      wr(UCB_OFF_CTL, 32'(tx_tab[i][15:8]), UCB_RESP_OKAY);
      wr(UCB_OFF_STAT, 32'h3, UCB_RESP_OKAY);
      wr(UCB_OFF_BUF, 32'(tx_tab[i][7:0]), UCB_RESP_OKAY);
      // A second byte while the frame is on the line must be dropped.
      wr(UCB_OFF_BUF, {24'h000000, ~tx_tab[i][7:0]}, UCB_RESP_OKAY);
      n = 0;
      while (irq_o !== 1'b1 && n < 600) begin
        @(posedge clk_sys_i);
        n++;
      end
      if (n >= 600) begin
        errors++;
        complete_run();
      end
      chk("ti_time", 32'h1, 32'(n >= 312 && n <= 326));
      repeat (60) @(posedge clk_sys_i);
      chk("tx_frame", 32'({1'b1, tx_tab[i][15] ? tx_tab[i][11] : 1'b1, tx_tab[i][7:0], 1'b0}),
        32'(i_ucb_remote.got));
      rd(UCB_OFF_CTL, 32'h42 | 32'(tx_tab[i][15:8]), UCB_RESP_OKAY);
      rd(UCB_OFF_BUF, 32'(last_rx), UCB_RESP_OKAY);
    end
    complete_run();
  end
endmodule
`default_nettype wire
